//--- inc/t8cwu_consts.svh
// Register offsets, flag positions and reset values of the timer compare unit.
`ifndef T8CWU_CONSTS_SVH
`define T8CWU_CONSTS_SVH
`define T8CWU_ADDR_CTRL 3'h0
`define T8CWU_ADDR_COUNT 3'h1
`define T8CWU_ADDR_COMPARE 3'h2
`define T8CWU_ADDR_FLAGS 3'h3
`define T8CWU_FLAG_WRAP 0
`define T8CWU_FLAG_MATCH 1
`define T8CWU_FORCE_BIT 7
`define T8CWU_COUNT_MAX 8'hFF
`define T8CWU_COUNT_BOTTOM 8'h00
`define T8CWU_COUNT_STEP 8'h01
`define T8CWU_RESET_BYTE 8'h00
`endif

//--- inc/t8cwu_pkg.sv
// Types and shared decode functions of the timer compare unit.
package t8cwu_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE = 2'h1,
    MODE_CLRMATCH = 2'h2,
    MODE_FAST = 2'h3
  } t8cwu_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_SET = 2'h3
  } t8cwu_action_t;

  // Layout of the timer control register, bit 7 down to bit 0.
  typedef struct packed {
    logic forceMatchStrobe;
    logic waveformModeLow;
    t8cwu_action_t outputActionSelect;
    logic waveformModeHigh;
    logic [2:0] clockSelect;
  } t8cwu_ctrl_t;

  // Events that steer the compare output bit.
  typedef struct packed {
    logic tick;
    logic hit;
    logic bottom;
    logic forced;
  } t8cwu_event_t;

  function automatic t8cwu_mode_t t8cwu_mode(input t8cwu_ctrl_t c);
    return t8cwu_mode_t'({c.waveformModeHigh, c.waveformModeLow});
  endfunction

  function automatic logic t8cwu_is_pwm(input t8cwu_mode_t m);
    return (m == MODE_FAST) || (m == MODE_PHASE);
  endfunction
endpackage

//--- rtl/t8cwu_compare_out.sv
// Compare output bit: match, bottom and forced actions.
`timescale 1ns/100ps
`default_nettype none
module t8cwu_compare_out import t8cwu_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire t8cwu_event_t ev,
  input wire t8cwu_ctrl_t ctrl,
  output logic compareOutputBit
);
  logic ocBit_reg;
  logic ocBit_next;
  t8cwu_mode_t mode;

  assign mode = t8cwu_mode(ctrl);
  assign compareOutputBit = ocBit_reg;

  function automatic logic applyAction(input t8cwu_action_t a, input logic cur);
    unique case (a)
      ACT_NONE: return cur;
      ACT_TOGGLE: return !cur;
      ACT_CLEAR: return 1'b0;
      ACT_SET: return 1'b1;
    endcase
  endfunction

  always_comb begin
    ocBit_next = ocBit_reg;
    if (ev.forced && !t8cwu_is_pwm(mode)) begin
      ocBit_next = applyAction(ctrl.outputActionSelect, ocBit_reg);
    end else if (ev.tick && mode != MODE_PHASE) begin
      if (ev.hit) begin
        ocBit_next = applyAction(ctrl.outputActionSelect, ocBit_reg);
      end
      // Bottom wins over a same-tick match, so compare at MAX holds a constant level with the clear and set actions.
      if (mode == MODE_FAST && ev.bottom) begin
        if (ctrl.outputActionSelect == ACT_CLEAR) begin
          ocBit_next = 1'b1;
        end else if (ctrl.outputActionSelect == ACT_SET) begin
          ocBit_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ocBit_reg <= 1'b0;
    end else begin
      ocBit_reg <= ocBit_next;
    end
  end

  a_action_none_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl.outputActionSelect == ACT_NONE) |=> $stable(ocBit_reg))
    else $error("compare output moved with no action selected");
endmodule
`default_nettype wire

//--- rtl/t8cwu_pin_mux.sv
// Port pin takeover by the compare output bit.
`timescale 1ns/100ps
`default_nettype none
module t8cwu_pin_mux import t8cwu_pkg::*; (
  input wire t8cwu_action_t outputActionSelect,
  input wire logic compareOutputBit,
  input wire logic portValue,
  input wire logic pinDirectionBit,
  output logic pinOut,
  output logic pinOe
);
  // Takeover ignores the waveform mode; direction stays with the port.
  assign pinOut = (outputActionSelect != ACT_NONE) ? compareOutputBit : portValue;
  assign pinOe = pinDirectionBit;
endmodule
`default_nettype wire

//--- rtl/t8cwu_top.sv
// Eight-bit timer counter, flags, compare register and register port.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "t8cwu_consts.svh"
module t8cwu_top import t8cwu_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic timerTick,
  input wire logic wrapAck,
  input wire logic matchAck,
  input wire logic portValue,
  input wire logic pinDirectionBit,
  output logic pinOut,
  output logic pinOe,
  output logic [2:0] clockSelect,
  output logic compareOutputBit,
  output logic wrapFlag,
  output logic matchFlag
);
  t8cwu_ctrl_t ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] compareBuf_reg;
  logic [7:0] compareActive_reg;
  logic wrapFlag_reg;
  logic matchFlag_reg;
  logic block_reg;
  logic forcePend_reg;
  logic [7:0] rdData_reg;

  logic ctrlWr;
  logic countWr;
  logic compareWr;
  logic flagsWr;
  t8cwu_mode_t mode;
  t8cwu_mode_t modeWritten;
  logic isPwm;
  logic atMax;
  logic compareHit;
  logic wrapSet;
  logic matchSet;
  t8cwu_event_t ev;

  assign ctrlWr = wrStrobe && (addr == `T8CWU_ADDR_CTRL);
  assign countWr = wrStrobe && (addr == `T8CWU_ADDR_COUNT);
  assign compareWr = wrStrobe && (addr == `T8CWU_ADDR_COMPARE);
  assign flagsWr = wrStrobe && (addr == `T8CWU_ADDR_FLAGS);

  assign mode = t8cwu_mode(ctrl_reg);
  assign modeWritten = t8cwu_mode(t8cwu_ctrl_t'(wrData));
  assign isPwm = t8cwu_is_pwm(mode);
  assign atMax = (count_reg == `T8CWU_COUNT_MAX);

  // A count write hides the comparator until the next tick has passed.
  assign compareHit = (count_reg == compareActive_reg) && !block_reg;
  assign matchSet = timerTick && compareHit;
  // The tick that leaves MAX is the wrap in every mode except MODE_PHASE.
  assign wrapSet = timerTick && atMax && !countWr && (mode != MODE_PHASE);

  assign ev.tick = timerTick;
  assign ev.hit = compareHit;
  assign ev.bottom = atMax && !countWr;
  assign ev.forced = forcePend_reg;

  assign rdData = rdData_reg;
  assign clockSelect = ctrl_reg.clockSelect;
  assign wrapFlag = wrapFlag_reg;
  assign matchFlag = matchFlag_reg;

  // Control register; the force bit is a strobe and is never stored.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= t8cwu_ctrl_t'(`T8CWU_RESET_BYTE);
    end else if (ctrlWr) begin
      ctrl_reg <= t8cwu_ctrl_t'(wrData);
      ctrl_reg.forceMatchStrobe <= 1'b0;
    end
  end

  // The force acts one cycle late so it sees the action written with it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      forcePend_reg <= 1'b0;
    end else begin
      forcePend_reg <= ctrlWr && wrData[`T8CWU_FORCE_BIT]
        && !t8cwu_is_pwm(modeWritten);
    end
  end

  // Counter; a software write has priority over any count or clear.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `T8CWU_RESET_BYTE;
    end else if (countWr) begin
      count_reg <= wrData;
    end else if (timerTick) begin
      if (mode == MODE_CLRMATCH && compareHit) begin
        count_reg <= `T8CWU_COUNT_BOTTOM;
      end else begin
        count_reg <= count_reg + `T8CWU_COUNT_STEP;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (countWr) begin
      block_reg <= 1'b1;
    end else if (timerTick) begin
      block_reg <= 1'b0;
    end
  end

  // Compare value: direct in non-PWM modes, buffered to the wrap in PWM modes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compareBuf_reg <= `T8CWU_RESET_BYTE;
    end else if (compareWr) begin
      compareBuf_reg <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compareActive_reg <= `T8CWU_RESET_BYTE;
    end else if (compareWr && !isPwm) begin
      compareActive_reg <= wrData;
    end else if (isPwm && timerTick && atMax && !countWr) begin
      compareActive_reg <= compareBuf_reg;
    end
  end

  // Flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrapFlag_reg <= 1'b0;
    end else if (wrapSet) begin
      wrapFlag_reg <= 1'b1;
    end else if (wrapAck || (flagsWr && wrData[`T8CWU_FLAG_WRAP])) begin
      wrapFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      matchFlag_reg <= 1'b0;
    end else if (matchSet) begin
      matchFlag_reg <= 1'b1;
    end else if (matchAck || (flagsWr && wrData[`T8CWU_FLAG_MATCH])) begin
      matchFlag_reg <= 1'b0;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= `T8CWU_RESET_BYTE;
    end else if (rdStrobe) begin
      unique case (addr)
        `T8CWU_ADDR_CTRL: rdData_reg <= ctrl_reg;
        `T8CWU_ADDR_COUNT: rdData_reg <= count_reg;
        `T8CWU_ADDR_COMPARE: rdData_reg <= compareBuf_reg;
        `T8CWU_ADDR_FLAGS: rdData_reg <= {6'h00, matchFlag_reg, wrapFlag_reg};
        default: rdData_reg <= `T8CWU_RESET_BYTE;
      endcase
    end else begin
      rdData_reg <= `T8CWU_RESET_BYTE;
    end
  end

  t8cwu_compare_out u_compare_out (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ev(ev),
    .ctrl(ctrl_reg),
    .compareOutputBit(compareOutputBit)
  );

  t8cwu_pin_mux u_pin_mux (
    .outputActionSelect(ctrl_reg.outputActionSelect),
    .compareOutputBit(compareOutputBit),
    .portValue(portValue),
    .pinDirectionBit(pinDirectionBit),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_normal_wrap: assert property (
    (timerTick && !countWr && mode == MODE_NORMAL && atMax) |=> (count_reg == 8'h00))
    else $error("normal mode did not wrap to zero");

  a_normal_step: assert property (
    (timerTick && !countWr && mode == MODE_NORMAL && !atMax)
      |=> (count_reg == $past(count_reg) + 8'h01))
    else $error("normal mode did not increment");

  a_wrap_flag_set: assert property (
    (timerTick && !countWr && atMax && mode != MODE_PHASE) |=> wrapFlag_reg && count_reg == 8'h00)
    else $error("wrap flag missing at the wrap");

  a_match_clear: assert property (
    (timerTick && !countWr && mode == MODE_CLRMATCH && compareHit) |=> (count_reg == 8'h00))
    else $error("clear-on-match mode did not clear");

  a_match_flag_set: assert property (
    (timerTick && compareHit) |=> matchFlag_reg)
    else $error("match flag not set after match");

  a_write_blocks: assert property (
    countWr |=> !compareHit)
    else $error("compare match seen after count write");

  a_force_no_flag: assert property (
    (forcePend_reg && !matchFlag_reg && !matchSet) |=> !matchFlag_reg)
    else $error("forced match set the match flag");

  a_idle_no_count: assert property (
    (!timerTick && !countWr) |=> $stable(count_reg))
    else $error("counter moved without a tick");

  a_pwm_buffered: assert property (
    (isPwm && compareWr && !(timerTick && atMax)) |=> $stable(compareActive_reg))
    else $error("compare value not buffered in PWM mode");

  a_pin_takeover: assert property (
    (ctrl_reg.outputActionSelect != ACT_NONE)
      |-> (pinOut == compareOutputBit && pinOe == pinDirectionBit))
    else $error("compare bit did not take over the pin");

  a_read_once: assert property (
    (rdStrobe && addr == `T8CWU_ADDR_COUNT && !timerTick && !countWr)
      |=> (rdData == count_reg) ##1 (rdData == 8'h00 || $past(rdStrobe)))
    else $error("count read data wrong");

  a_fast_clear: assert property (
    (timerTick && !countWr && mode == MODE_FAST && atMax) |=> (count_reg == 8'h00))
    else $error("fast PWM did not restart from zero");

  a_fast_step: assert property (
    (timerTick && !countWr && mode == MODE_FAST && !atMax)
      |=> (count_reg == $past(count_reg) + 8'h01))
    else $error("fast PWM did not increment");

  a_clear_mode_step: assert property (
    (timerTick && !countWr && mode == MODE_CLRMATCH && !compareHit)
      |=> (count_reg == $past(count_reg) + 8'h01))
    else $error("clear-on-match mode did not count past a missed match");

  a_wrap_flag_hold: assert property (
    (wrapFlag_reg && !wrapAck && !(flagsWr && wrData[`T8CWU_FLAG_WRAP])) |=> wrapFlag_reg)
    else $error("wrap flag cleared without acknowledge or write");

  a_wrap_ack_clear: assert property (
    (wrapAck && !wrapSet) |=> !wrapFlag_reg)
    else $error("wrap acknowledge did not clear the flag");

  a_wrap_only_edge: assert property (
    (!wrapSet && !wrapFlag_reg) |=> !wrapFlag_reg)
    else $error("wrap flag rose without a wrap");

  a_phase_no_wrap: assert property (
    (mode == MODE_PHASE && !wrapFlag_reg) |=> !wrapFlag_reg)
    else $error("wrap flag rose in dual-slope mode");

  a_match_flag_hold: assert property (
    (matchFlag_reg && !matchAck && !(flagsWr && wrData[`T8CWU_FLAG_MATCH])) |=> matchFlag_reg)
    else $error("match flag cleared without acknowledge or write");

  a_match_ack_clear: assert property (
    (matchAck && !matchSet) |=> !matchFlag_reg)
    else $error("match acknowledge did not clear the flag");

  a_match_only_hit: assert property (
    (!matchSet && !matchFlag_reg) |=> !matchFlag_reg)
    else $error("match flag rose without a counted match");

  a_block_clears: assert property (
    (block_reg && timerTick && !countWr) |=> !block_reg)
    else $error("match blocking outlived the following tick");

  a_block_match: assert property (
    (block_reg && timerTick) |=> (!matchFlag_reg || $past(matchFlag_reg)))
    else $error("blocked tick set the match flag");

  a_compare_direct: assert property (
    (compareWr && !isPwm) |=> (compareActive_reg == $past(wrData)))
    else $error("compare value not direct in non-PWM mode");

  a_pwm_reload: assert property (
    (isPwm && timerTick && atMax && !countWr) |=> (compareActive_reg == $past(compareBuf_reg)))
    else $error("buffered compare value not loaded at the wrap");

  a_force_not_stored: assert property (
    !ctrl_reg.forceMatchStrobe)
    else $error("force strobe was stored in the control register");

  a_ctrl_read: assert property (
    (rdStrobe && addr == `T8CWU_ADDR_CTRL) |=> (rdData == $past(ctrl_reg)))
    else $error("control read data wrong");

  a_read_idle_zero: assert property (
    !rdStrobe |=> (rdData == 8'h00))
    else $error("read data stood outside the read cycle");

  a_pin_port: assert property (
    (ctrl_reg.outputActionSelect == ACT_NONE) |-> (pinOut == portValue))
    else $error("port value lost with no output action");
endmodule
`default_nettype wire

//--- testbench/t8cwu_port_model.sv
// Port pin model: port value and direction latches plus a pulled-up pad.
`timescale 1ns/100ps
`default_nettype none
module t8cwu_port_model import t8cwu_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pinWrEn,
  input wire logic [1:0] pinWrVal,
  input wire logic pinOut,
  input wire logic pinOe,
  output logic portValue,
  output logic pinDirectionBit,
  output logic padLevel
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portValue <= 1'b0;
      pinDirectionBit <= 1'b0;
    end else if (pinWrEn) begin
      {pinDirectionBit, portValue} <= pinWrVal;
    end
  end
  // An undriven pad floats to the pull-up level, so a stale value never shows.
  assign padLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

//--- testbench/tb_t8cwu_top.sv
// Self-checking bench of the timer compare unit and its port pin.
`timescale 1ns/100ps
`default_nettype none
`include "t8cwu_consts.svh"
module tb_t8cwu_top import t8cwu_pkg::*; ();
  logic clk_sys, rst_n, wrStrobe, rdStrobe, timerTick, wrapAck, matchAck;
  logic portValue, pinDirectionBit, pinOut, pinOe, compareOutputBit;
  logic wrapFlag, matchFlag, padLevel, pinWrEn;
  logic [1:0] pinWrVal;
  logic [2:0] addr, clockSelect;
  logic [7:0] wrData, rdData, rv;
  int failCount, samplesChecked, cycles;

  t8cwu_top i_t8cwu_top (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .timerTick(timerTick),
    .wrapAck(wrapAck), .matchAck(matchAck), .portValue(portValue),
    .pinDirectionBit(pinDirectionBit), .pinOut(pinOut), .pinOe(pinOe),
    .clockSelect(clockSelect),
    .compareOutputBit(compareOutputBit), .wrapFlag(wrapFlag), .matchFlag(matchFlag));
  t8cwu_port_model i_t8cwu_port_model (.clk_sys(clk_sys), .rst_n(rst_n), .pinWrEn(pinWrEn),
    .pinWrVal(pinWrVal), .pinOut(pinOut), .pinOe(pinOe), .portValue(portValue),
    .pinDirectionBit(pinDirectionBit), .padLevel(padLevel));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hang is cut short well above the few thousand cycles the run needs.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      conclude();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({8'h00, seen}, {8'h00, exp});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    #1;
    rv = rdData;
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys);
    timerTick <= 1'b1;
    repeat (n) @(posedge clk_sys);
    timerTick <= 1'b0;
    #1;
  endtask
  task automatic ack(input logic w);
    @(posedge clk_sys);
    wrapAck <= w;
    matchAck <= !w;
    @(posedge clk_sys);
    wrapAck <= 1'b0;
    matchAck <= 1'b0;
    #1;
  endtask
  task automatic pin(input logic [1:0] v);
    @(posedge clk_sys);
    pinWrEn <= 1'b1;
    pinWrVal <= v;
    @(posedge clk_sys);
    pinWrEn <= 1'b0;
    #1;
  endtask
  // The forced action lands one edge after the control write is taken.
  task automatic frc(input logic [7:0] d);
    wr(`T8CWU_ADDR_CTRL, d);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic testReset();
    chk1(compareOutputBit, 1'b0);
    chk1(pinOe, 1'b0);
    check({6'h00, clockSelect}, 9'h000);
    rd(`T8CWU_ADDR_CTRL);
    check({1'b0, rv}, 9'h000);
    rd(3'h5);
    check({1'b0, rv}, 9'h000);
  endtask

  task automatic testForce();
    frc(8'hB0);
    chk1(compareOutputBit, 1'b1);
    chk1(matchFlag, 1'b0);
    chk1(padLevel, 1'b1);
    rd(`T8CWU_ADDR_CTRL);
    check({1'b0, rv}, 9'h030);
    pin(2'b10);
    chk1(pinOut, 1'b1);
    frc(8'hA0);
    chk1(pinOut, 1'b0);
    pin(2'b11);
    wr(`T8CWU_ADDR_CTRL, 8'h2D);
    chk1(pinOut, 1'b0);
    check({6'h00, clockSelect}, 9'h005);
    frc(8'h80);
    chk1(compareOutputBit, 1'b0);
    chk1(pinOut, 1'b1);
  endtask

  task automatic testNormal();
    wr(`T8CWU_ADDR_COUNT, 8'hFD);
    ticks(3);
    chk1(wrapFlag, 1'b1);
    rd(`T8CWU_ADDR_COUNT);
    check({1'b0, rv}, 9'h000);
    ticks(1);
    chk1(matchFlag, 1'b1);
    chk1(wrapFlag, 1'b1);
    rd(`T8CWU_ADDR_FLAGS);
    check({1'b0, rv}, 9'h003);
    wr(`T8CWU_ADDR_FLAGS, 8'h01);
    chk1(wrapFlag, 1'b0);
    ack(1'b0);
    chk1(matchFlag, 1'b0);
    wr(`T8CWU_ADDR_COUNT, 8'hFF);
    ticks(1);
    chk1(wrapFlag, 1'b1);
    ack(1'b1);
    chk1(wrapFlag, 1'b0);
    wr(`T8CWU_ADDR_COUNT, 8'h00);
    ticks(2);
    chk1(matchFlag, 1'b0);
    wr(`T8CWU_ADDR_CTRL, 8'h40);
    wr(`T8CWU_ADDR_COUNT, 8'hFF);
    ticks(1);
    chk1(wrapFlag, 1'b0);
    frc(8'hF0);
    chk1(compareOutputBit, 1'b0);
    wr(`T8CWU_ADDR_CTRL, 8'h00);
  endtask

  // Measures the spacing of output toggles with the timer ticking every cycle.
  task automatic testClearOnMatch();
    logic [7:0] cmps [3] = '{8'h00, 8'h02, 8'h05};
    logic last;
    int n;
    foreach (cmps[i]) begin
      wr(`T8CWU_ADDR_COMPARE, cmps[i]);
      wr(`T8CWU_ADDR_COUNT, 8'h00);
      wr(`T8CWU_ADDR_CTRL, 8'h18);
      @(posedge clk_sys);
      timerTick <= 1'b1;
      for (int k = 0; k < 2; k++) begin
        last = compareOutputBit;
        n = 0;
        while (compareOutputBit === last && n < 600) begin
          @(posedge clk_sys);
          #1;
          n++;
        end
      end
      @(posedge clk_sys);
      timerTick <= 1'b0;
      check(9'(n), 9'h001 + {1'b0, cmps[i]});
    end
  endtask

  // Counts high cycles over one full period after the buffered compare took effect.
  task automatic testFast();
    logic [7:0] ctl [5] = '{8'h68, 8'h78, 8'h68, 8'h68, 8'h78};
    logic [7:0] cmp [5] = '{8'h40, 8'h40, 8'h00, 8'hFF, 8'hFF};
    logic [8:0] hi [5] = '{9'h041, 9'h0BF, 9'h001, 9'h100, 9'h000};
    int n;
    foreach (ctl[i]) begin
      wr(`T8CWU_ADDR_COMPARE, cmp[i]);
      rd(`T8CWU_ADDR_COMPARE);
      check({1'b0, rv}, {1'b0, cmp[i]});
      wr(`T8CWU_ADDR_CTRL, ctl[i]);
      @(posedge clk_sys);
      timerTick <= 1'b1;
      repeat (300) @(posedge clk_sys);
      wr(`T8CWU_ADDR_FLAGS, 8'h01);
      n = 0;
      repeat (256) begin
        @(posedge clk_sys);
        #1;
        n += int'(compareOutputBit === 1'b1);
      end
      check(9'(n), hi[i]);
      chk1(wrapFlag, 1'b1);
      @(posedge clk_sys);
      timerTick <= 1'b0;
    end
  endtask

  initial begin
    {rst_n, wrStrobe, rdStrobe, timerTick, wrapAck, matchAck, pinWrEn} = '0;
    {addr, wrData, pinWrVal} = '0;
    failCount = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    testReset();
    testForce();
    testNormal();
    testClearOnMatch();
    testFast();
    conclude();
  end
endmodule
`default_nettype wire
